// ===== design/scope_trigger_pkg.sv
// Package: register map, fields, encodings and types for the scope trigger unit
package scope_trigger_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_SLOPE    = 12'h004;
  localparam logic [11:0] ADDR_RISING   = 12'h008;
  localparam logic [11:0] ADDR_FALLING  = 12'h00c;
  localparam logic [11:0] ADDR_FORCE    = 12'h010;
  localparam logic [11:0] ADDR_LEVEL    = 12'h014;
  localparam logic [11:0] ADDR_HYST_ABS = 12'h018;
  localparam logic [11:0] ADDR_HYST_REL = 12'h01c;
  localparam logic [11:0] ADDR_FSCALE   = 12'h020;
  localparam logic [11:0] ADDR_HOLD_T   = 12'h024;
  localparam logic [11:0] ADDR_HOLD_N   = 12'h028;
  localparam logic [11:0] ADDR_DELAY    = 12'h02c;
  localparam logic [11:0] ADDR_REF      = 12'h030;
  localparam logic [11:0] ADDR_STATUS   = 12'h034;

  // ==========================================================================
  // Control and status field positions
  localparam int CTRL_TRIG_EN   = 0;
  localparam int CTRL_GATE_EN   = 1;
  localparam int CTRL_HOLD_MODE = 2;
  localparam int CTRL_HYST_MODE = 3;
  localparam int CTRL_SRC_LSB   = 4;
  localparam int CTRL_GATE_LSB  = 6;
  localparam int STAT_STATE     = 0;
  localparam int STAT_ARMED     = 1;
  localparam int STAT_BUSY      = 2;

  // ==========================================================================
  // Widths and sizes
  localparam int SAMPLE_W = 16;
  localparam int REC_LEN  = 64;
  localparam int PTR_W    = 6;
  localparam int FRAC_W   = 16;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] REF_HALF     = 16'h8000;
  localparam logic [31:0] HOLD_N_RESET = 32'h0000_0001;
  localparam logic [31:0] ZERO32       = 32'h0000_0000;

  // ==========================================================================
  // Encodings
  typedef enum logic [1:0] {
    SLOPE_NONE = 2'h0, SLOPE_RISE = 2'h1, SLOPE_FALL = 2'h2, SLOPE_BOTH = 2'h3
  } slope_t;

  typedef enum logic [1:0] {
    GATE_IN3_HIGH = 2'h0, GATE_IN3_LOW = 2'h1, GATE_IN4_HIGH = 2'h2, GATE_IN4_LOW = 2'h3
  } gate_sel_t;

  typedef enum logic [1:0] {
    SRC_SIGIN1 = 2'h0, SRC_SIGIN2 = 2'h1, SRC_TRIGIN1 = 2'h2, SRC_TRIGIN2 = 2'h3
  } source_t;

  localparam logic HOLD_TIME  = 1'b0;
  localparam logic HOLD_COUNT = 1'b1;
  localparam logic HYST_ABS   = 1'b0;
  localparam logic HYST_REL   = 1'b1;

  // Gray-coded acquisition states along the usual path
  typedef enum logic [1:0] {
    ST_FILL   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_POST   = 2'b11,
    ST_STREAM = 2'b10
  } acq_state_t;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic [SAMPLE_W-1:0] data;
    logic                last;
  } stream_beat_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] sigin1;
    logic [SAMPLE_W-1:0] sigin2;
  } analog_in_t;

endpackage : scope_trigger_pkg

// ===== design/scope_trigger_unit.sv
// Scope trigger unit: APB registers, edge trigger, holdoff, capture and record stream
`timescale 1ns/1ns
module scope_trigger_unit
(
  // Clock and reset
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // APB slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [11:0]                           paddr,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Sample inputs, same clock
  input  wire scope_trigger_pkg::analog_in_t         samples,
  // Trigger input pins, asynchronous
  input  wire logic [3:0]                            trig_in,
  // Record stream
  output scope_trigger_pkg::stream_beat_t            rec_beat,
  output logic                                       rec_valid,
  input  wire logic                                  rec_ready,
  // Trigger indication
  output logic                                       trig_pulse
);

  localparam int W = scope_trigger_pkg::SAMPLE_W;
  localparam int P = scope_trigger_pkg::PTR_W;

  // ==========================================================================
  // Helpers
  function automatic logic [W-1:0] frac_of(input logic [W-1:0] v, input logic [31:0] f);
    logic [W+31:0] prod;
    prod = {{32{1'b0}}, v} * {{W{1'b0}}, f};
    frac_of = (prod[W+31:scope_trigger_pkg::FRAC_W] > {{16{1'b0}}, {W{1'b1}}})
              ? {W{1'b1}} : prod[W+scope_trigger_pkg::FRAC_W-1:scope_trigger_pkg::FRAC_W];
  endfunction : frac_of

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (s[i])
        merge[i*8 +: 8] = d[i*8 +: 8];
  endfunction : merge

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] trig_meta_reg;
  logic [3:0] trig_sync_reg;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      trig_meta_reg <= 4'h0;
      trig_sync_reg <= 4'h0;
    end
    else
    begin
      trig_meta_reg <= trig_in;
      trig_sync_reg <= trig_meta_reg;
    end

  // ==========================================================================
  // Register file
  logic [31:0] ctrl_reg, ctrl_next;
  logic [1:0]  slope_reg, slope_next;
  logic        force_reg, force_next;
  logic [31:0] level_reg, level_next, habs_reg, habs_next, hrel_reg, hrel_next;
  logic [31:0] fscale_reg, fscale_next, holdt_reg, holdt_next, holdn_reg, holdn_next;
  logic [31:0] delay_reg, delay_next, ref_reg, ref_next;
  logic [31:0] prdata_next;
  logic        pready_reg, pready_next, pslverr_next;
  logic        state_flag, armed_reg, busy;

  wire access = psel && penable && !pready_reg;
  wire wr     = access && pwrite;

  always_comb
  begin
    ctrl_next    = ctrl_reg;
    slope_next   = slope_reg;
    force_next   = 1'b0;
    level_next   = level_reg;
    habs_next    = habs_reg;
    hrel_next    = hrel_reg;
    fscale_next  = fscale_reg;
    holdt_next   = holdt_reg;
    holdn_next   = holdn_reg;
    delay_next   = delay_reg;
    ref_next     = ref_reg;
    prdata_next  = 32'h0000_0000;
    pready_next  = access;
    pslverr_next = 1'b0;
    if (wr)
      unique case (paddr)
        scope_trigger_pkg::ADDR_CTRL:     ctrl_next   = merge(ctrl_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_SLOPE:    if (pstrb[0]) slope_next = pwdata[1:0];
        scope_trigger_pkg::ADDR_RISING:   if (pstrb[0]) slope_next[0] = pwdata[0];
        scope_trigger_pkg::ADDR_FALLING:  if (pstrb[0]) slope_next[1] = pwdata[0];
        scope_trigger_pkg::ADDR_FORCE:    force_next  = 1'b1;
        scope_trigger_pkg::ADDR_LEVEL:    level_next  = merge(level_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_HYST_ABS: habs_next   = merge(habs_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_HYST_REL: hrel_next   = merge(hrel_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_FSCALE:   fscale_next = merge(fscale_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_HOLD_T:   holdt_next  = merge(holdt_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_HOLD_N:   holdn_next  = merge(holdn_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_DELAY:    delay_next  = merge(delay_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_REF:      ref_next    = merge(ref_reg, pwdata, pstrb);
        scope_trigger_pkg::ADDR_STATUS:   pslverr_next = 1'b1;
        default:                          pslverr_next = 1'b1;
      endcase
    else if (access)
      unique case (paddr)
        scope_trigger_pkg::ADDR_CTRL:     prdata_next = ctrl_reg;
        scope_trigger_pkg::ADDR_SLOPE:    prdata_next = {30'h0, slope_reg};
        scope_trigger_pkg::ADDR_RISING:   prdata_next = {31'h0, slope_reg[0]};
        scope_trigger_pkg::ADDR_FALLING:  prdata_next = {31'h0, slope_reg[1]};
        scope_trigger_pkg::ADDR_FORCE:    prdata_next = 32'h0000_0000;
        scope_trigger_pkg::ADDR_LEVEL:    prdata_next = level_reg;
        scope_trigger_pkg::ADDR_HYST_ABS: prdata_next = habs_reg;
        scope_trigger_pkg::ADDR_HYST_REL: prdata_next = hrel_reg;
        scope_trigger_pkg::ADDR_FSCALE:   prdata_next = fscale_reg;
        scope_trigger_pkg::ADDR_HOLD_T:   prdata_next = holdt_reg;
        scope_trigger_pkg::ADDR_HOLD_N:   prdata_next = holdn_reg;
        scope_trigger_pkg::ADDR_DELAY:    prdata_next = delay_reg;
        scope_trigger_pkg::ADDR_REF:      prdata_next = ref_reg;
        scope_trigger_pkg::ADDR_STATUS:   prdata_next = {29'h0, busy, armed_reg, state_flag};
        default:                          pslverr_next = 1'b1;
      endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_reg   <= 32'h0000_0000;
      slope_reg  <= scope_trigger_pkg::SLOPE_RISE;
      force_reg  <= 1'b0;
      level_reg  <= scope_trigger_pkg::ZERO32;
      habs_reg   <= scope_trigger_pkg::ZERO32;
      hrel_reg   <= scope_trigger_pkg::ZERO32;
      fscale_reg <= scope_trigger_pkg::ZERO32;
      holdt_reg  <= scope_trigger_pkg::ZERO32;
      holdn_reg  <= scope_trigger_pkg::HOLD_N_RESET;
      delay_reg  <= scope_trigger_pkg::ZERO32;
      ref_reg    <= {16'h0000, scope_trigger_pkg::REF_HALF};
      prdata     <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr    <= 1'b0;
    end
    else
    begin
      ctrl_reg   <= ctrl_next;
      slope_reg  <= slope_next;
      force_reg  <= force_next;
      level_reg  <= level_next;
      habs_reg   <= habs_next;
      hrel_reg   <= hrel_next;
      fscale_reg <= fscale_next;
      holdt_reg  <= holdt_next;
      holdn_reg  <= holdn_next;
      delay_reg  <= delay_next;
      ref_reg    <= ref_next;
      prdata     <= prdata_next;
      pready_reg <= pready_next;
      pslverr    <= pslverr_next;
    end
  assign pready = pready_reg;

  // ==========================================================================
  // Source selection, crossing detection and rearm
  logic [W-1:0] src, prev_reg, prev_next, hyst;
  logic [31:0]  hold_cnt_reg, hold_cnt_next, ev_cnt_reg, ev_cnt_next;
  logic         armed_next, hyst_ok_reg, hyst_ok_next, trig_next, gate_ok;
  logic         rise, fall, edge_hit, event_ok, record_now;
  wire  [W-1:0] lvl = level_reg[W-1:0];

  always_comb
  begin
    unique case (scope_trigger_pkg::source_t'(ctrl_reg[scope_trigger_pkg::CTRL_SRC_LSB +: 2]))
      scope_trigger_pkg::SRC_SIGIN1:  src = samples.sigin1;
      scope_trigger_pkg::SRC_SIGIN2:  src = samples.sigin2;
      scope_trigger_pkg::SRC_TRIGIN1: src = {W{trig_sync_reg[0]}};
      scope_trigger_pkg::SRC_TRIGIN2: src = {W{trig_sync_reg[1]}};
    endcase
    unique case (scope_trigger_pkg::gate_sel_t'(ctrl_reg[scope_trigger_pkg::CTRL_GATE_LSB +: 2]))
      scope_trigger_pkg::GATE_IN3_HIGH: gate_ok = trig_sync_reg[2];
      scope_trigger_pkg::GATE_IN3_LOW:  gate_ok = !trig_sync_reg[2];
      scope_trigger_pkg::GATE_IN4_HIGH: gate_ok = trig_sync_reg[3];
      scope_trigger_pkg::GATE_IN4_LOW:  gate_ok = !trig_sync_reg[3];
    endcase
    hyst = (ctrl_reg[scope_trigger_pkg::CTRL_HYST_MODE] == scope_trigger_pkg::HYST_REL)
           ? frac_of(fscale_reg[W-1:0], hrel_reg) : habs_reg[W-1:0];
    rise = slope_reg[0] && (prev_reg < lvl) && (src >= lvl);
    fall = slope_reg[1] && (prev_reg > lvl) && (src <= lvl);
    edge_hit = armed_reg && (rise || fall);
    event_ok = (edge_hit || force_reg) &&
               (!ctrl_reg[scope_trigger_pkg::CTRL_GATE_EN] || gate_ok);
    trig_next = (rise || fall) &&
                (!ctrl_reg[scope_trigger_pkg::CTRL_GATE_EN] || gate_ok);
    prev_next = src;
    ev_cnt_next = ev_cnt_reg;
    record_now = 1'b0;
    if (event_ok)
    begin
      if (ctrl_reg[scope_trigger_pkg::CTRL_HOLD_MODE] == scope_trigger_pkg::HOLD_COUNT)
      begin
        if (ev_cnt_reg + 32'h1 >= holdn_reg)
        begin
          record_now  = 1'b1;
          ev_cnt_next = 32'h0;
        end
        else
          ev_cnt_next = ev_cnt_reg + 32'h1;
      end
      else
        record_now = 1'b1;
    end
    hold_cnt_next = (hold_cnt_reg != 32'h0) ? hold_cnt_reg - 32'h1 : hold_cnt_reg;
    hyst_ok_next  = hyst_ok_reg;
    armed_next    = armed_reg;
    if (record_now)
    begin
      armed_next    = 1'b0;
      hyst_ok_next  = (hyst == {W{1'b0}});
      hold_cnt_next = (ctrl_reg[scope_trigger_pkg::CTRL_HOLD_MODE] == scope_trigger_pkg::HOLD_TIME)
                      ? holdt_reg : 32'h0;
    end
    else if (!armed_reg)
    begin
      // Hysteresis side follows the enabled edge
      if ((slope_reg[0] && ({1'b0, src} + {1'b0, hyst} <= {1'b0, lvl})) ||
          (slope_reg[1] && ({1'b0, src} >= {1'b0, lvl} + {1'b0, hyst})))
        hyst_ok_next = 1'b1;
      armed_next = hyst_ok_reg && (hold_cnt_reg == 32'h0);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prev_reg     <= {W{1'b0}};
      armed_reg    <= 1'b1;
      hyst_ok_reg  <= 1'b1;
      hold_cnt_reg <= 32'h0;
      ev_cnt_reg   <= 32'h0;
      state_flag   <= 1'b0;
      trig_pulse   <= 1'b0;
    end
    else
    begin
      prev_reg     <= prev_next;
      armed_reg    <= armed_next;
      hyst_ok_reg  <= hyst_ok_next;
      hold_cnt_reg <= hold_cnt_next;
      ev_cnt_reg   <= ev_cnt_next;
      state_flag   <= trig_next;
      trig_pulse   <= record_now;
    end

  // ==========================================================================
  // Capture ring and record stream
  // Pre-trigger depth = ref fraction of record minus delay, clamped to record
  logic [W-1:0]       ring [scope_trigger_pkg::REC_LEN];
  logic [P-1:0]       wptr_reg, wptr_next, rptr_reg, rptr_next, left_reg, left_next;
  logic [P:0]         fill_reg, fill_next, pre;
  scope_trigger_pkg::acq_state_t st_reg, st_next;
  logic               rv_next, rlast_next;
  logic [W-1:0]       rdat_next;
  logic signed [33:0] pre_s;
  wire                trig_mode = ctrl_reg[scope_trigger_pkg::CTRL_TRIG_EN];
  wire                drain     = rec_valid && rec_ready;

  always_comb
  begin
    pre_s = $signed({2'b00, ref_reg} * 34'sd0) +
            $signed({18'h0, ref_reg[15:0]} >>> 10) - $signed({{2{delay_reg[31]}}, delay_reg});
    pre   = (pre_s < 0) ? '0 : (pre_s > scope_trigger_pkg::REC_LEN) ?
            (P+1)'(scope_trigger_pkg::REC_LEN) : pre_s[P:0];
    st_next = st_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    left_next = left_reg;
    fill_next = fill_reg;
    rv_next = rec_valid;
    rdat_next = rec_beat.data;
    rlast_next = rec_beat.last;
    if (st_reg != scope_trigger_pkg::ST_STREAM)
    begin
      wptr_next = wptr_reg + P'(1);
      if (fill_reg != (P+1)'(scope_trigger_pkg::REC_LEN))
        fill_next = fill_reg + (P+1)'(1);
    end
    unique case (st_reg)
      scope_trigger_pkg::ST_FILL:
        if (fill_reg >= pre)
          st_next = scope_trigger_pkg::ST_WAIT;
      scope_trigger_pkg::ST_WAIT:
        if (!trig_mode || record_now)
        begin
          st_next   = scope_trigger_pkg::ST_POST;
          left_next = P'(scope_trigger_pkg::REC_LEN - 1) - pre[P-1:0];
          rptr_next = wptr_reg - pre[P-1:0];
        end
      scope_trigger_pkg::ST_POST:
        if (left_reg == '0)
        begin
          st_next   = scope_trigger_pkg::ST_STREAM;
          left_next = P'(scope_trigger_pkg::REC_LEN - 1);
        end
        else
          left_next = left_reg - P'(1);
      scope_trigger_pkg::ST_STREAM:
        if (!rec_valid || drain)
        begin
          if (rec_valid && rec_beat.last)
          begin
            rv_next   = 1'b0;
            st_next   = scope_trigger_pkg::ST_FILL;
            fill_next = '0;
          end
          else
          begin
            rv_next    = 1'b1;
            rdat_next  = ring[rptr_reg];
            rlast_next = (left_reg == '0);
            rptr_next  = rptr_reg + P'(1);
            left_next  = left_reg - P'(1);
          end
        end
    endcase
  end

  // Last post cycle lands on the oldest slot, so it must not overwrite it
  always_ff @(posedge pclk)
    if (st_reg != scope_trigger_pkg::ST_STREAM &&
        !(st_reg == scope_trigger_pkg::ST_POST && left_reg == '0))
      ring[wptr_reg] <= src;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      st_reg    <= scope_trigger_pkg::ST_FILL;
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      left_reg  <= '0;
      fill_reg  <= '0;
      rec_valid <= 1'b0;
      rec_beat  <= '0;
    end
    else
    begin
      st_reg        <= st_next;
      wptr_reg      <= wptr_next;
      rptr_reg      <= rptr_next;
      left_reg      <= left_next;
      fill_reg      <= fill_next;
      rec_valid     <= rv_next;
      rec_beat.data <= rdat_next;
      rec_beat.last <= rlast_next;
    end
  assign busy = (st_reg != scope_trigger_pkg::ST_WAIT);

endmodule : scope_trigger_unit

// ===== sim/scope_trigger_unit_asserts.sv
// Checker: bus and record stream properties of the scope trigger unit
`timescale 1ns/1ns
module scope_trigger_unit_asserts
(
  // Clock and reset
  input wire logic                            pclk,
  input wire logic                            presetn,
  // APB
  input wire logic                            psel,
  input wire logic                            penable,
  input wire logic                            pwrite,
  input wire logic [11:0]                     paddr,
  input wire logic                            pready,
  input wire logic                            pslverr,
  // Record stream and trigger
  input wire scope_trigger_pkg::stream_beat_t rec_beat,
  input wire logic                            rec_valid,
  input wire logic                            rec_ready,
  input wire logic                            trig_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // Bus
  sequence s_acc;
    psel && penable && !pready;
  endsequence
  AST_ANSWER: assert property (s_acc |=> pready)
    else $error("access not answered after one wait");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_ERR_PAIR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_STATUS_WR: assert property
    (s_acc ##0 (pwrite && paddr == scope_trigger_pkg::ADDR_STATUS) |=> pslverr)
    else $error("status write not refused");
  AST_UNMAPPED: assert property
    (s_acc ##0 (paddr > scope_trigger_pkg::ADDR_STATUS) |=> pslverr)
    else $error("unmapped access not refused");
  AST_READ_OK: assert property (s_acc ##0 (!pwrite && paddr[1:0] == 2'h0
    && paddr <= scope_trigger_pkg::ADDR_STATUS) |=> !pslverr)
    else $error("mapped read refused");
  // ==========
  // Stream and trigger
  sequence s_last;
    rec_valid && rec_ready && rec_beat.last;
  endsequence
  AST_BEAT_HOLD: assert property
    (rec_valid && !rec_ready |=> rec_valid && $stable(rec_beat))
    else $error("beat changed while stalled");
  AST_LAST_END: assert property
    (s_last |=> !rec_valid) else $error("valid after last beat");
  AST_PULSE_ONE: assert property
    (trig_pulse |=> !trig_pulse) else $error("trigger pulse too long");
endmodule : scope_trigger_unit_asserts

bind scope_trigger_unit scope_trigger_unit_asserts u_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pready(pready), .pslverr(pslverr), .rec_beat(rec_beat),
  .rec_valid(rec_valid), .rec_ready(rec_ready), .trig_pulse(trig_pulse));

// ===== sim/test_scope_trigger_unit.sv
// Testbench: self-checking run of the scope trigger unit
`timescale 1ns/1ns
module test_scope_trigger_unit;
  logic        pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, rec_valid, trig_pulse, rec_ready = 1'b0, rd_e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_v, seed = 32'd10645;
  logic [15:0] ramp = 16'h0;
  logic [15:0] rec [64];
  logic [3:0]  trig_in = 4'h0;
  logic [7:0]  cv;
  int          fails = 0, total_checks = 0, cyc = 0, pulses = 0, p0;
  int          dl [3] = '{16, 0, -16};
  scope_trigger_pkg::analog_in_t   samples = '0;
  scope_trigger_pkg::stream_beat_t rec_beat;

  scope_trigger_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .samples(samples),
    .trig_in(trig_in), .rec_beat(rec_beat), .rec_valid(rec_valid),
    .rec_ready(rec_ready), .trig_pulse(trig_pulse));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Gate pins: selected pin passes when ok, the other pin always opposite
  function logic [3:0] gpins(input logic [1:0] g, input logic ok);
    logic lvl;
    lvl = g[0] ^ ok;
    return {g[1] ? lvl : !lvl, g[1] ? !lvl : lvl, 2'b00};
  endfunction : gpins

  task wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) fails++;
    rd_v = prdata;
    rd_e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task rchk(input string w, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(w, e, rd_v);
  endtask : rchk

  // Drop the rest of a record already streaming
  task flush;
    int n;
    n = 0;
    do @(posedge pclk);
    while (rec_valid === 1'b1 && !(rec_ready === 1'b1 && rec_beat.last === 1'b1) && ++n < 300);
  endtask : flush

  task settle(input int tail);
    flush();
    repeat (150) @(posedge pclk);
    flush();
    repeat (tail) @(posedge pclk);
  endtask : settle

  task get_rec;
    int i;
    int n;
    i = 0;
    n = 0;
    while (i < 64 && n < 3000)
    begin
      @(posedge pclk);
      n++;
      if (rec_valid === 1'b1 && rec_ready === 1'b1)
      begin
        rec[i] = rec_beat.data;
        chk("last flag", {31'h0, i == 63}, {31'h0, rec_beat.last});
        i++;
      end
    end
    chk("beats", 32'd64, i);
  endtask : get_rec

  task fire;
    apb(1'b1, scope_trigger_pkg::ADDR_FORCE, 32'h1);
    repeat (20) @(posedge pclk);
  endtask : fire

  // ==========
  // Sources, stall pattern and timeout
  always @(posedge pclk)
  begin
    cyc++;
    if (trig_pulse === 1'b1) pulses++;
    seed <= xs(seed);
    rec_ready <= seed[3:0] != 4'h0;
    ramp <= ramp + 16'h1;
    samples.sigin1 <= ramp;
    samples.sigin2 <= ramp[5] ? 16'hf000 : 16'h0000;
    if (cyc == 20000)
    begin
      fails++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("ctrl", scope_trigger_pkg::ADDR_CTRL, 32'h0);
    rchk("rising", scope_trigger_pkg::ADDR_RISING, 32'h1);
    rchk("holdn", scope_trigger_pkg::ADDR_HOLD_N, scope_trigger_pkg::HOLD_N_RESET);
    rchk("ref", scope_trigger_pkg::ADDR_REF, {16'h0, scope_trigger_pkg::REF_HALF});
    rchk("delay", scope_trigger_pkg::ADDR_DELAY, 32'h0);
    repeat (2)
    begin
      flush();
      get_rec();
      for (int k = 1; k < 64; k++) chk("ramp", 16'(rec[k-1] + 1), rec[k]);
    end
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, scope_trigger_pkg::ADDR_SLOPE, 32'(s));
      rchk("rising", scope_trigger_pkg::ADDR_RISING, s & 1);
      rchk("falling", scope_trigger_pkg::ADDR_FALLING, s >> 1);
      rchk("slope", scope_trigger_pkg::ADDR_SLOPE, s);
    end
    apb(1'b1, scope_trigger_pkg::ADDR_RISING, 32'h0);
    rchk("slope", scope_trigger_pkg::ADDR_SLOPE, 32'h2);
    apb(1'b1, scope_trigger_pkg::ADDR_FALLING, 32'h0);
    rchk("slope", scope_trigger_pkg::ADDR_SLOPE, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      cv = (k == 0) ? 8'hff : seed[7:0];
      apb(1'b1, scope_trigger_pkg::ADDR_CTRL, {24'h0, cv});
      rchk("ctrl", scope_trigger_pkg::ADDR_CTRL, {24'h0, cv});
    end
    apb(1'b0, 12'h038, 32'h0);
    chk("unmapped err", 32'h1, rd_e);
    apb(1'b1, scope_trigger_pkg::ADDR_STATUS, 32'h1);
    chk("status wr err", 32'h1, rd_e);
    rchk("force rd", scope_trigger_pkg::ADDR_FORCE, 32'h0);
    apb(1'b1, scope_trigger_pkg::ADDR_LEVEL, 32'h8000);
    apb(1'b1, scope_trigger_pkg::ADDR_SLOPE, 32'h1);
    apb(1'b1, scope_trigger_pkg::ADDR_CTRL, 32'h11);
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, scope_trigger_pkg::ADDR_DELAY, 32'(dl[k]));
      settle(0);
      get_rec();
      chk("pre low", 32'h0, rec[24 - dl[k]]);
      chk("post high", 32'hf000, rec[40 - dl[k]]);
    end
    apb(1'b1, scope_trigger_pkg::ADDR_SLOPE, 32'h0);
    apb(1'b1, scope_trigger_pkg::ADDR_DELAY, 32'h0);
    for (int g = 0; g < 4; g++)
    begin
      apb(1'b1, scope_trigger_pkg::ADDR_CTRL, 32'h3 | (g << 6));
      trig_in <= gpins(2'(g), 1'b0);
      settle(80);
      p0 = pulses;
      fire();
      chk("gated force", p0, pulses);
      trig_in <= gpins(2'(g), 1'b1);
      repeat (5) @(posedge pclk);
      fire();
      chk("force", p0 + 1, pulses);
    end
    apb(1'b1, scope_trigger_pkg::ADDR_HOLD_N, 32'h2);
    apb(1'b1, scope_trigger_pkg::ADDR_CTRL, 32'h5);
    settle(80);
    p0 = pulses;
    fire();
    chk("first event", p0, pulses);
    fire();
    chk("second event", p0 + 1, pulses);
    wrap_up();
  end
endmodule : test_scope_trigger_unit
